// ---- logic/rtc_core.v ----
// Calendar clock top: counters, alarm, countdown, protection, standby RAM, tamper, registers.
// Assumes resetn_in is the supply-level power-on reset and register requests are on clk_in.
`include "rtc_defs.vh"
module rtc_core #(
    parameter        UNLOCK_LEN   = 3,
    parameter [7:0]  UNLOCK_CODES = 8'h1e,
    parameter [29:0] UNLOCK_CYC   = `RTC_UNLOCK_CYC,
    parameter [29:0] POR_CYC      = `RTC_POR_CYC
) (
    input  wire        clk_in,
    input  wire        resetn_in,
    input  wire        ce_in,
    input  wire        bus_clk_en_in,
    input  wire        crystal_input_in,
    input  wire [1:0]  tamper_pin_in,
    input  wire        battery_lost_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [5:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    output reg  [15:0] reg_rdata_out,
    output reg         reg_ack_out,
    output reg         reg_err_out,
    output wire        irq_out,
    output reg         alarm_out
);
    reg [7:0]  year;
    reg [3:0]  mon;
    reg [4:0]  day;
    reg [2:0]  dow;
    reg [4:0]  hour;
    reg [5:0]  mins;
    reg [5:0]  sec;
    reg [7:0]  a_year;
    reg [3:0]  a_mon;
    reg [4:0]  a_day;
    reg [4:0]  a_hour;
    reg [5:0]  a_min;
    reg [5:0]  a_sec;
    reg [4:2]  ctl;
    reg [9:0]  isr;
    reg [9:0]  ier;
    reg [7:0]  cdt;
    reg [7:0]  comp_val;
    reg [7:0]  comp_int;
    reg [15:0] tcfg;
    reg [2:0]  tsrc;
    reg [15:0] ts_ym;
    reg [15:0] ts_dy;
    reg [15:0] ts_hm;
    reg [15:0] ts_sc;
    reg [9:0]  dst_hr;
    reg [7:0]  dst_mon;
    reg [9:0]  dst_day;
    reg        dst_rep;
    reg [29:0] ulk_cnt;
    reg [29:0] por_cnt;
    reg [2:0]  step;
    reg [7:0]  ram [0:31];
    reg [15:0] rv;
    reg        rok;
    integer    k;

    wire       tick;
    wire       sec_t;
    wire [6:0] samp;
    wire       unstable;
    wire [2:0] det;

    ////////////////////////////////////////////////////////////////////////////
    function leap;
        input [7:0] y;
        leap = (y[1:0] == 2'b00) && y != `RTC_NOLEAP_A && y != `RTC_NOLEAP_B;
    endfunction

    function [4:0] dim;
        input [3:0] m;
        input [7:0] y;
        case (m)
            4'h2: dim = leap(y) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: dim = 5'h1e;
            default: dim = 5'h1f;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    rtc_presc u_presc (
        .clk_in           (clk_in),
        .resetn_in        (resetn_in),
        .ce_in            (ce_in),
        .crystal_input_in (crystal_input_in),
        .comp_val_in      (comp_val),
        .comp_int_in      (comp_int),
        .tick_out         (tick),
        .sec_out          (sec_t),
        .samp_out         (samp),
        .unstable_out     (unstable)
    );

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_tamp
            rtc_tfilt u_filt (
                .clk_in    (clk_in),
                .resetn_in (resetn_in),
                .ce_in     (ce_in),
                .tick_in   (tick),
                .pin_in    (g == 2 ? battery_lost_in : tamper_pin_in[g % 2]),
                .pol_in    (g == 2 ? 1'b1 : tcfg[2 + g]),
                .en_in     (g == 2 ? tcfg[4] : tcfg[g]), // RL16
                .width_in  (g == 2 ? 8'h00 : tcfg[15:8]),
                .det_out   (det[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    wire unlocked = ulk_cnt != 30'h0;
    wire por_win  = por_cnt != 30'h0;
    wire wr_ok    = unlocked | por_win;
    wire is_ctl   = reg_addr_in == `RTC_A_CTRL;
    wire acc_w    = bus_clk_en_in & reg_wr_in; // RL19
    wire acc_r    = bus_clk_en_in & reg_rd_in & ~reg_wr_in;
    wire w_err    = ~rok | (~is_ctl & ~wr_ok); // RL21
    wire wr_go    = acc_w & ~w_err;
    wire code_hit = reg_wdata_in[1:0] == UNLOCK_CODES[2 * step +: 2]; // RL24

    wire [15:0] w_ym = {year, 4'h0, mon};
    wire [15:0] w_dy = {5'h00, dow, 3'h0, day};
    wire [15:0] w_hm = {3'h0, hour, 2'h0, mins};
    wire [15:0] w_sc = {10'h000, sec};

    wire min_roll  = sec_t && sec == 6'h3b;
    wire hour_roll = min_roll && mins == 6'h3b;
    wire at_start  = ctl[`RTC_CTL_DST] && mon == dst_mon[7:4] && day == dst_day[9:5] && hour == dst_hr[9:5];
    wire at_end    = ctl[`RTC_CTL_DST] && mon == dst_mon[3:0] && day == dst_day[4:0] && hour == dst_hr[4:0];

    wire match = sec == a_sec && mins == a_min && hour == a_hour && // RL2
                 (~ctl[`RTC_CTL_FULL] || (day == a_day && mon == a_mon && year == a_year)); // RL3

    wire [9:0] isr_set = {samp, min_roll && ctl[`RTC_CTL_CDEN] && cdt == 8'h01, // RL5
                          match & ~alarm_out, |det}; // RL18
    wire [9:0] isr_clr = (wr_go && reg_addr_in == `RTC_A_ISR) ? reg_wdata_in[9:0] : 10'h000;
    wire [2:0] src_clr = (wr_go && reg_addr_in == `RTC_A_TAMP_SRC) ? reg_wdata_in[2:0] : 3'h0;

    assign irq_out = |(isr & ier); // RL2

    ////////////////////////////////////////////////////////////////////////////
    // Read view; reserved bits stay zero
    always @* begin
        rv  = 16'h0000;
        rok = 1'b1;
        if (reg_addr_in[`RTC_RAM_BIT]) begin
            rv = {8'h00, ram[reg_addr_in[4:0]]}; // RL14
        end else begin
            case (reg_addr_in)
                `RTC_A_YRMON:     rv = w_ym;
                `RTC_A_DAYS:      rv = w_dy;
                `RTC_A_HOURMIN:   rv = w_hm;
                `RTC_A_SECONDS:   rv = w_sc;
                `RTC_A_ALM_YRMON: rv = {a_year, 4'h0, a_mon};
                `RTC_A_ALM_DAYS:  rv = {11'h000, a_day};
                `RTC_A_ALM_HM:    rv = {3'h0, a_hour, 2'h0, a_min};
                `RTC_A_ALM_SEC:   rv = {10'h000, a_sec};
                `RTC_A_CTRL:      rv = {11'h000, ctl, 2'b00};
                `RTC_A_STATUS:    rv = {13'h0000, por_win, unlocked, unstable}; // RL23
                `RTC_A_ISR:       rv = {6'h00, isr};
                `RTC_A_IER:       rv = {6'h00, ier};
                `RTC_A_COUNTDOWN: rv = {8'h00, cdt};
                `RTC_A_COMPEN:    rv = {comp_int, comp_val};
                `RTC_A_TAMP_CFG:  rv = tcfg;
                `RTC_A_TAMP_SRC:  rv = {13'h0000, tsrc};
                `RTC_A_TS_YRMON:  rv = ts_ym;
                `RTC_A_TS_DAYS:   rv = ts_dy;
                `RTC_A_TS_HM:     rv = ts_hm;
                `RTC_A_TS_SEC:    rv = ts_sc;
                `RTC_A_DST_HOUR:  rv = {3'h0, dst_hr[9:5], 3'h0, dst_hr[4:0]};
                `RTC_A_DST_MONTH: rv = {4'h0, dst_mon[7:4], 4'h0, dst_mon[3:0]};
                `RTC_A_DST_DAY:   rv = {3'h0, dst_day[9:5], 3'h0, dst_day[4:0]};
                default:          rok = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Only the supply-level reset clears this state
    always @(posedge clk_in or negedge resetn_in) begin // RL13
        if (!resetn_in) begin
            year          <= 8'h00;
            mon           <= `RTC_MON_RST;
            day           <= `RTC_DAY_RST;
            dow           <= 3'h0;
            hour          <= 5'h00;
            mins          <= 6'h00;
            sec           <= 6'h00;
            a_year        <= 8'h00;
            a_mon         <= 4'h0;
            a_day         <= 5'h00;
            a_hour        <= 5'h00;
            a_min         <= 6'h00;
            a_sec         <= 6'h00;
            ctl           <= 3'h0;
            isr           <= `RTC_ISR_RST; // RL18
            ier           <= `RTC_IER_RST;
            cdt           <= 8'h00;
            comp_val      <= 8'h00;
            comp_int      <= 8'h00;
            tcfg          <= `RTC_TCFG_RST; // RL18
            tsrc          <= 3'h0;
            ts_ym         <= 16'h0000;
            ts_dy         <= 16'h0000;
            ts_hm         <= 16'h0000;
            ts_sc         <= 16'h0000;
            dst_hr        <= 10'h000;
            dst_mon       <= 8'h00;
            dst_day       <= 10'h000;
            dst_rep       <= 1'b0;
            ulk_cnt       <= 30'h0;
            por_cnt       <= POR_CYC; // RL11
            step          <= 3'h0;
            alarm_out     <= 1'b0;
            reg_rdata_out <= 16'h0000;
            reg_ack_out   <= 1'b0;
            reg_err_out   <= 1'b0;
            for (k = 0; k < 32; k = k + 1)
                ram[k] <= 8'h00;
        end else if (ce_in) begin
            // Timekeeping runs from the crystal tick regardless of bus gating
            if (sec_t) begin // RL1
                sec <= (sec == 6'h3b) ? 6'h00 : sec + 6'h01;
            end
            if (min_roll) begin
                mins <= (mins == 6'h3b) ? 6'h00 : mins + 6'h01;
                if (ctl[`RTC_CTL_CDEN] && cdt != 8'h00)
                    cdt <= cdt - 8'h01; // RL5
            end
            if (hour_roll) begin
                if (at_start) begin
                    hour <= hour + 5'h02; // RL1
                end else if (at_end && !dst_rep) begin
                    dst_rep <= 1'b1;
                end else begin
                    dst_rep <= 1'b0;
                    if (hour == 5'h17) begin
                        hour <= 5'h00;
                        dow  <= (dow == 3'h6) ? 3'h0 : dow + 3'h1;
                        if (day == dim(mon, year)) begin // RL1
                            day <= 5'h01;
                            if (mon == 4'hc) begin
                                mon  <= 4'h1;
                                year <= year + 8'h01;
                            end else begin
                                mon <= mon + 4'h1;
                            end
                        end else begin
                            day <= day + 5'h01;
                        end
                    end else begin
                        hour <= hour + 5'h01;
                    end
                end
            end
            alarm_out <= match; // RL4
            isr       <= (isr & ~isr_clr) | isr_set; // RL6
            tsrc      <= (tsrc & ~src_clr) | det; // RL15
            if (|det) begin
                ts_ym <= w_ym; // RL18
                ts_dy <= w_dy;
                ts_hm <= w_hm;
                ts_sc <= w_sc;
            end
            if (por_win)
                por_cnt <= por_cnt - 30'h1; // RL11
            if (unlocked)
                ulk_cnt <= ulk_cnt - 30'h1; // RL10
            // Enable field writes never error; ctl changes only when wr_ok
            if (acc_w && is_ctl) begin // RL12
                if (unlocked) begin
                    ulk_cnt <= 30'h0; // RL9
                    step    <= 3'h0;
                end else if (!code_hit) begin
                    step <= 3'h0; // RL8
                end else if (step == UNLOCK_LEN - 1) begin
                    ulk_cnt <= UNLOCK_CYC; // RL8
                    step    <= 3'h0;
                end else begin
                    step <= step + 3'h1;
                end
            end
            // Software writes take priority over counting in the same cycle
            if (wr_go) begin
                if (reg_addr_in[`RTC_RAM_BIT]) begin
                    ram[reg_addr_in[4:0]] <= reg_wdata_in[7:0]; // RL14
                end else begin
                    case (reg_addr_in)
                        `RTC_A_YRMON: begin
                            year <= reg_wdata_in[15:8];
                            mon  <= reg_wdata_in[3:0];
                        end
                        `RTC_A_DAYS: begin
                            dow <= reg_wdata_in[10:8];
                            day <= reg_wdata_in[4:0];
                        end
                        `RTC_A_HOURMIN: begin
                            hour <= reg_wdata_in[12:8];
                            mins <= reg_wdata_in[5:0];
                        end
                        `RTC_A_SECONDS:   sec <= reg_wdata_in[5:0];
                        `RTC_A_ALM_YRMON: begin
                            a_year <= reg_wdata_in[15:8];
                            a_mon  <= reg_wdata_in[3:0];
                        end
                        `RTC_A_ALM_DAYS:  a_day <= reg_wdata_in[4:0];
                        `RTC_A_ALM_HM: begin
                            a_hour <= reg_wdata_in[12:8];
                            a_min  <= reg_wdata_in[5:0];
                        end
                        `RTC_A_ALM_SEC:   a_sec <= reg_wdata_in[5:0];
                        `RTC_A_CTRL:      if (wr_ok) ctl <= reg_wdata_in[4:2]; // RL12
                        `RTC_A_IER:       ier <= reg_wdata_in[9:0];
                        `RTC_A_COUNTDOWN: cdt <= reg_wdata_in[7:0];
                        `RTC_A_COMPEN: begin
                            comp_int <= reg_wdata_in[15:8]; // RL7
                            comp_val <= reg_wdata_in[7:0];
                        end
                        `RTC_A_TAMP_CFG:  tcfg <= {reg_wdata_in[15:8], 3'h0, reg_wdata_in[4:0]};
                        `RTC_A_DST_HOUR:  dst_hr <= {reg_wdata_in[12:8], reg_wdata_in[4:0]};
                        `RTC_A_DST_MONTH: dst_mon <= {reg_wdata_in[11:8], reg_wdata_in[3:0]};
                        `RTC_A_DST_DAY:   dst_day <= {reg_wdata_in[12:8], reg_wdata_in[4:0]};
                        default: ;
                    endcase
                end
            end
            // One-cycle answer to every accepted access
            reg_ack_out <= acc_w | acc_r;
            reg_err_out <= (acc_w & w_err) | (acc_r & ~rok); // RL21
            if (acc_r)
                reg_rdata_out <= rok ? rv : 16'hffff; // RL20
        end
    end
endmodule // rtc_core

// ---- logic/rtc_defs.vh ----
// Shared constants of the battery-backed calendar clock: offsets, fields, resets, timing.
// Assumes a 40 MHz system clock and a synchronised 32.768 kHz crystal sample path.
// Function
// RL1: Calendar counters with leap year and daylight saving
// RL2: Time match sets alarm flag, enabled interrupt
// RL3: Optional date match extends alarm comparison
// RL4: Alarm condition driven out as wake source
// RL5: Minute countdown with enable and expiry interrupt
// RL6: Seven periodic sampling interrupt sources
// RL7: Software compensation value corrects 1 Hz tick
// RL8: Correct code sequence unlocks protected registers
// RL9: Any write to enable field relocks
// RL10: Unlock window lasts at most two seconds
// RL11: Fifteen second open window after power-on
// RL12: Enable bits always writable, rest protected; code accepts control writes but changes ctl only when wr_ok
// RL13: Reset only from supply-level power-on
// RL14: Thirty-two byte standby RAM kept on battery
// RL15: Two tamper inputs with enable and polarity
// RL16: Battery removal selectable as tamper event
// RL17: Tamper inputs pass digital low-pass filter
// RL18: Tamper enabled at reset, interrupts, time-stamps
// RL19: Bus gating stops register access, not timekeeping
// RL20: Reserved bits read zero; reads always allowed
// RL21: Bad or locked writes, reserved reads error
// RL22: Software supplies only valid time values
// RL23: Status bit zero flags unstable counters
// RL24: Unlock codes and length are parameters
// RL25: Crystal domain events synchronised safely
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

`define RTC_CLK_HZ       40000000
`define RTC_UNLOCK_S     2
`define RTC_POR_S        15
`define RTC_UNLOCK_CYC   (`RTC_UNLOCK_S * `RTC_CLK_HZ)
`define RTC_POR_CYC      (`RTC_POR_S * `RTC_CLK_HZ)
`define RTC_PRESC_TOP    15'h7fff
`define RTC_UNSTABLE_TICKS 15'h0004

`define RTC_A_YRMON      6'h00
`define RTC_A_DAYS       6'h01
`define RTC_A_HOURMIN    6'h02
`define RTC_A_SECONDS    6'h03
`define RTC_A_ALM_YRMON  6'h04
`define RTC_A_ALM_DAYS   6'h05
`define RTC_A_ALM_HM     6'h06
`define RTC_A_ALM_SEC    6'h07
`define RTC_A_CTRL       6'h08
`define RTC_A_STATUS     6'h09
`define RTC_A_ISR        6'h0a
`define RTC_A_IER        6'h0b
`define RTC_A_COUNTDOWN  6'h0c
`define RTC_A_COMPEN     6'h0d
`define RTC_A_TAMP_CFG   6'h0e
`define RTC_A_TAMP_SRC   6'h0f
`define RTC_A_TS_YRMON   6'h10
`define RTC_A_TS_DAYS    6'h11
`define RTC_A_TS_HM      6'h12
`define RTC_A_TS_SEC     6'h13
`define RTC_A_DST_HOUR   6'h14
`define RTC_A_DST_MONTH  6'h15
`define RTC_A_DST_DAY    6'h16
`define RTC_RAM_BIT      5

`define RTC_CTL_FULL     2
`define RTC_CTL_CDEN     3
`define RTC_CTL_DST      4
`define RTC_IS_TMPR      0
`define RTC_IS_ALM       1
`define RTC_IS_CDT       2
`define RTC_ISR_RST      10'h001
`define RTC_IER_RST      10'h001
`define RTC_TCFG_RST     16'h001f
`define RTC_MON_RST      4'h1
`define RTC_DAY_RST      5'h01
`define RTC_NOLEAP_A     8'hf4
`define RTC_NOLEAP_B     8'h58

`endif

// ---- logic/rtc_presc.v ----
// 32.768 kHz prescaler with 1 Hz compensation, sampling events and unstable window.
// Assumes the crystal input is asynchronous to clk_in and much slower than it.
`include "rtc_defs.vh"
module rtc_presc (
    input  wire       clk_in,
    input  wire       resetn_in,
    input  wire       ce_in,
    input  wire       crystal_input_in,
    input  wire [7:0] comp_val_in,
    input  wire [7:0] comp_int_in,
    output reg        tick_out,
    output reg        sec_out,
    output reg  [6:0] samp_out,
    output reg        unstable_out
);
    reg        xs1;
    reg        xs2;
    reg        xs3;
    reg [14:0] presc;
    reg [7:0]  ccnt;
    integer    i;

    wire        tick  = xs2 & ~xs3; // RL25
    // Positive value shortens the corrected second
    wire [14:0] limit = (ccnt == 8'h00 && comp_int_in != 8'h00) ?
                        `RTC_PRESC_TOP - {{7{comp_val_in[7]}}, comp_val_in} : `RTC_PRESC_TOP; // RL7

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            xs1       <= 1'b0;
            xs2       <= 1'b0;
            xs3       <= 1'b0;
            presc     <= 15'h0000;
            ccnt      <= 8'h00;
            tick_out  <= 1'b0;
            sec_out   <= 1'b0;
            samp_out  <= 7'h00;
            unstable_out <= 1'b0;
        end else if (ce_in) begin
            xs1       <= crystal_input_in; // RL25
            xs2       <= xs1;
            xs3       <= xs2;
            tick_out  <= tick;
            sec_out   <= tick && presc >= limit;
            unstable_out <= (limit - presc) < `RTC_UNSTABLE_TICKS; // RL23
            for (i = 0; i < 7; i = i + 1)
                samp_out[i] <= tick && ((presc & (15'h3fff >> i)) == (15'h3fff >> i)); // RL6
            if (tick) begin
                if (presc >= limit) begin
                    presc <= 15'h0000;
                    ccnt  <= (ccnt == 8'h00) ? comp_int_in - 8'h01 : ccnt - 8'h01; // RL7
                end else begin
                    presc <= presc + 15'h0001;
                end
            end
        end
    end
endmodule // rtc_presc

// ---- logic/rtc_tfilt.v ----
// One tamper input: synchroniser, polarity, enable and digital low-pass filter.
// Assumes tick_in is a one-cycle pulse at the crystal rate.
module rtc_tfilt (
    input  wire       clk_in,
    input  wire       resetn_in,
    input  wire       ce_in,
    input  wire       tick_in,
    input  wire       pin_in,
    input  wire       pol_in,
    input  wire       en_in,
    input  wire [7:0] width_in,
    output reg        det_out
);
    reg       ps1;
    reg       ps2;
    reg       hit;
    reg [7:0] cnt;

    wire act = en_in & (ps2 == pol_in); // RL15

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ps1     <= 1'b0;
            ps2     <= 1'b0;
            hit     <= 1'b0;
            cnt     <= 8'h00;
            det_out <= 1'b0;
        end else if (ce_in) begin
            ps1     <= pin_in;
            ps2     <= ps1;
            det_out <= 1'b0;
            if (!act) begin
                cnt <= 8'h00;
                hit <= 1'b0;
            end else if (tick_in) begin
                // Level must hold width_in+1 crystal ticks before it counts
                if (cnt < width_in) begin
                    cnt <= cnt + 8'h01; // RL17
                end else if (!hit) begin
                    hit     <= 1'b1;
                    det_out <= 1'b1;
                end
            end
        end
    end
endmodule // rtc_tfilt

// ---- tb/rtc_core_properties.sv ----
// Port-level checker for the calendar clock top: register answers, errors, gating, reset.
// Assumes one clk_in domain and the asynchronous active-low resetn_in.
module rtc_core_properties (
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        ce_in,
    input wire logic        bus_clk_en_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [5:0]  reg_addr_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        reg_ack_out,
    input wire logic        reg_err_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    ////////////////////////////////////////////////////////////////////////////
    wire take = ce_in && bus_clk_en_in && (reg_wr_in || reg_rd_in);
    wire bad  = (reg_addr_in > 6'h16) && (reg_addr_in < 6'h20);
    ////////////////////////////////////////////////////////////////////////////
    AST_ACK_TAKEN: assert property (take |=> reg_ack_out) else $error("access not answered");
    AST_GATED_SILENT: assert property (!take |=> !reg_ack_out) else $error("ack without access");
    AST_ERR_WITH_ACK: assert property (reg_err_out |-> reg_ack_out) else $error("error without ack");
    AST_BAD_READ: assert property (take && !reg_wr_in && bad |=> reg_err_out && reg_rdata_out == 16'hffff)
        else $error("unmapped read answer wrong");
    AST_GOOD_READ: assert property (take && !reg_wr_in && !bad |=> !reg_err_out) else $error("valid read refused");
    AST_BAD_WRITE: assert property (take && reg_wr_in && bad |=> reg_err_out) else $error("unmapped write accepted");
    AST_CTRL_OPEN: assert property (take && reg_wr_in && reg_addr_in == 6'h08 |=> !reg_err_out)
        else $error("control write refused");
    AST_IRQ_AT_RESET: assert property ($rose(resetn_in) |-> irq_out) else $error("tamper irq not set");
    AST_RDATA_HOLD: assert property (!(take && !reg_wr_in) |=> $stable(reg_rdata_out))
        else $error("read data moved");
endmodule // rtc_core_properties

bind rtc_core rtc_core_properties i_rtc_core_properties (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .bus_clk_en_in(bus_clk_en_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out), .reg_err_out(reg_err_out), .irq_out(irq_out));

// ---- tb/tb.sv ----
// Self-checking bench for the calendar clock top with shortened protection windows.
// Assumes the fixed one-cycle answer latency; crystal ticks every 16 system clocks.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 0, resetn_in = 0, bus_clk_en_in = 1, crystal_input_in = 0, battery_lost_in = 0;
    logic        reg_wr_in = 0, reg_rd_in = 0;
    logic [1:0]  tamper_pin_in = 0;
    logic [5:0]  reg_addr_in = 0;
    logic [15:0] reg_wdata_in = 0, rd;
    wire  [15:0] reg_rdata_out;
    wire         reg_ack_out, reg_err_out, irq_out, alarm_out;
    int          errors = 0, total_checks = 0;
    rtc_core #(.UNLOCK_CYC(30'd200), .POR_CYC(30'd300)) i_rtc_core (.clk_in(clk_in), .resetn_in(resetn_in),
        .ce_in(1'b1), .bus_clk_en_in(bus_clk_en_in), .crystal_input_in(crystal_input_in),
        .tamper_pin_in(tamper_pin_in), .battery_lost_in(battery_lost_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out), .reg_err_out(reg_err_out),
        .irq_out(irq_out), .alarm_out(alarm_out));
    initial forever #12.5 clk_in = ~clk_in;
    always begin
        repeat (8) @(posedge clk_in);
        crystal_input_in <= ~crystal_input_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    task test_done;
        if (errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic c, input string m);
        total_checks++;
        if (c !== 1'b1) begin
            errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task acc(input logic w, input logic [5:0] a, input logic [15:0] d, input logic e);
        @(posedge clk_in);
        reg_wr_in <= w; reg_rd_in <= ~w; reg_addr_in <= a; reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0; reg_rd_in <= 1'b0;
        #1 chk(reg_ack_out === 1'b1 && reg_err_out === e, "ack or err");
        rd = reg_rdata_out;
    endtask
    task rdc(input logic [5:0] a, input logic [15:0] m, input logic [15:0] x);
        acc(1'b0, a, 16'h0000, 1'b0);
        chk((rd & m) === x, "read data");
    endtask
    task unlock;
        acc(1'b1, 6'h08, 16'h0002, 1'b0);
        acc(1'b1, 6'h08, 16'h0003, 1'b0);
        acc(1'b1, 6'h08, 16'h0001, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25.0 * 60000) errors++;
        test_done;
    end
    task t_reset_values;
        rdc(6'h00, 16'hffff, 16'h0001);
        rdc(6'h01, 16'hffff, 16'h0001);
        rdc(6'h0e, 16'hffff, 16'h001f);
        rdc(6'h0b, 16'hffff, 16'h0001);
        rdc(6'h0a, 16'h0003, 16'h0003);
        chk(irq_out === 1'b1, "tamper irq");
        chk(alarm_out === 1'b1, "alarm out");
    endtask
    task t_alarm;
        acc(1'b1, 6'h07, 16'h0005, 1'b0);
        @(posedge clk_in);
        #1 chk(alarm_out === 1'b0, "alarm out stuck");
        acc(1'b1, 6'h0a, 16'h0002, 1'b0);
        rdc(6'h0a, 16'h0002, 16'h0000);
    endtask
    task t_registers;
        acc(1'b1, 6'h25, 16'h12ab, 1'b0);
        rdc(6'h25, 16'hffff, 16'h00ab);
        acc(1'b1, 6'h0c, 16'hffff, 1'b0);
        rdc(6'h0c, 16'hffff, 16'h00ff);
        acc(1'b1, 6'h18, 16'h1234, 1'b1);
        acc(1'b0, 6'h1f, 16'h0000, 1'b1);
        chk(rd === 16'hffff, "reserved read data");
    endtask
    task t_gating;
        @(posedge clk_in);
        bus_clk_en_in <= 1'b0; reg_rd_in <= 1'b1;
        @(posedge clk_in);
        bus_clk_en_in <= 1'b1; reg_rd_in <= 1'b0;
        #1 chk(reg_ack_out === 1'b0, "gated access answered");
    endtask
    task t_power_on_lock;
        repeat (300) @(posedge clk_in);
        rdc(6'h09, 16'h0006, 16'h0000);
        acc(1'b1, 6'h25, 16'h0055, 1'b1);
        rdc(6'h25, 16'hffff, 16'h00ab);
        acc(1'b1, 6'h08, 16'h001c, 1'b0);
        rdc(6'h08, 16'hffff, 16'h0000);
    endtask
    task t_unlock;
        acc(1'b1, 6'h08, 16'h0002, 1'b0);
        acc(1'b1, 6'h08, 16'h0001, 1'b0);
        acc(1'b1, 6'h08, 16'h0003, 1'b0);
        acc(1'b1, 6'h08, 16'h0001, 1'b0);
        acc(1'b1, 6'h25, 16'h0066, 1'b1);
        unlock;
        rdc(6'h09, 16'h0002, 16'h0002);
        acc(1'b1, 6'h25, 16'h0077, 1'b0);
        rdc(6'h25, 16'hffff, 16'h0077);
        acc(1'b1, 6'h08, 16'h0004, 1'b0);
        rdc(6'h08, 16'hffff, 16'h0004);
        acc(1'b1, 6'h25, 16'h0011, 1'b1);
        unlock;
        repeat (210) @(posedge clk_in);
        acc(1'b1, 6'h25, 16'h0022, 1'b1);
    endtask
    task t_tamper;
        unlock;
        acc(1'b1, 6'h0e, 16'h081f, 1'b0);
        acc(1'b1, 6'h0a, 16'h03ff, 1'b0);
        acc(1'b1, 6'h0f, 16'h0007, 1'b0);
        @(posedge clk_in);
        tamper_pin_in <= 2'b10;
        repeat (48) @(posedge clk_in);
        tamper_pin_in <= 2'b01; battery_lost_in <= 1'b1;
        repeat (300) @(posedge clk_in);
        rdc(6'h0f, 16'h0007, 16'h0005);
        rdc(6'h0a, 16'h0001, 16'h0001);
        chk(irq_out === 1'b1, "tamper irq");
    endtask
    task t_sampling;
        repeat (9000) @(posedge clk_in);
        rdc(6'h0a, 16'h0300, 16'h0300);
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        t_reset_values;
        t_alarm;
        t_registers;
        t_gating;
        t_power_on_lock;
        t_unlock;
        t_tamper;
        t_sampling;
        test_done;
    end
endmodule // tb
